// *** cpg_gate.sv ***
// code protection gate for table and programmer accesses
//
// Overview of operation
// - program memory splits into boot region up to 2 Kbytes and two binary blocks
// - each region has external lock, write lock and cross-region read lock
// - external lock ignores processor accesses but blocks programmer reads and writes
// - write lock at zero refuses table writes into that region
// - cross-read lock at zero still lets reads from inside the region through
// - cross-read lock at zero refuses reads from outside, table latch gets zero
// - protection bits only clear through writes; writing one to zero does nothing
// - only reset or a programmer chip or block erase sets protection bits back to one
// - eeprom external lock blocks all programmer reads and writes of eeprom
// - eeprom write lock blocks every eeprom write from processor or programmer
// - processor may always read eeprom whatever the protection settings
// - config write lock guards config registers; processor cannot change it
// - table access reaches program memory, config registers and device id word
// - eight id bytes at 200000h-200007h are read and written by table access
// - id bytes stay readable while code protection is active
`timescale 1ns/100ps
`include "cpg_regs.svh"
module cpg_gate #(
  parameter int unsigned     MEM_BYTES   = 8192,
  parameter int unsigned     BOOT_BYTES  = 2048,
  parameter cpg_pkg::cpg_byte_t DEVID_LOW  = 8'h00, // arbitrary value
  parameter cpg_pkg::cpg_byte_t DEVID_HIGH = 8'h00  // arbitrary value
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  // processor table access port
  input  wire logic               core_req,
  input  wire logic               core_wr,
  input  wire logic               core_ee,
  input  wire cpg_pkg::cpg_addr_t table_pointer,
  input  wire cpg_pkg::cpg_addr_t core_pc,
  input  wire cpg_pkg::cpg_byte_t core_wdata,
  output logic                    core_done,
  output logic                    core_refused,
  // external programmer port
  input  wire logic               prog_req,
  input  wire logic               prog_wr,
  input  wire logic               prog_ee,
  input  wire cpg_pkg::cpg_addr_t prog_addr,
  input  wire cpg_pkg::cpg_byte_t prog_wdata,
  input  wire logic               prog_chip_erase,
  input  wire logic               prog_block_erase,
  input  wire cpg_pkg::cpg_region_e prog_erase_sel,
  output logic                    prog_done,
  output logic                    prog_refused,
  // shared read result
  output cpg_pkg::cpg_byte_t      table_latch,
  // program memory and data eeprom side
  output logic                    mem_rd,
  output logic                    mem_wr,
  output logic                    ee_rd,
  output logic                    ee_wr,
  output cpg_pkg::cpg_addr_t      nvm_addr,
  output cpg_pkg::cpg_byte_t      nvm_wdata,
  input  wire cpg_pkg::cpg_byte_t mem_rdata,
  input  wire cpg_pkg::cpg_byte_t ee_rdata,
  output logic                    erase_strobe,
  output logic [2:0]              erase_regions,
  output logic                    erase_eeprom
);
  import cpg_pkg::*;

  // protection bits; the three region vectors are indexed by region, eeprom and config bits are single
  logic [2:0]  region_external_lock;
  logic [2:0]  region_write_lock;
  logic [2:0]  region_cross_read_lock;
  logic        eeprom_external_lock;
  logic        eeprom_write_lock;
  logic        config_write_lock;

  // sequencer and the request held for it
  cpg_state_e  state;
  cpg_state_e  next_state;
  logic        cur_src_prog;
  logic        cur_wr;
  logic        cur_ok;
  cpg_target_e cur_tgt;
  cpg_addr_t   cur_addr;

  // selected request, decided in the cycle it is taken
  logic        accept;
  logic        sel_prog;
  logic        sel_wr;
  logic        sel_ee;
  cpg_addr_t   sel_addr;
  cpg_byte_t   sel_wdata;
  cpg_target_e next_tgt;
  logic        next_ok;
  cpg_region_e tr;
  cpg_region_e pr;
  logic        cfg_wr_en;

  logic [2:0]  next_ext;
  logic [2:0]  next_wrl;
  logic [2:0]  next_xrd;
  logic        next_ee_ext;
  logic        next_ee_wrl;
  logic        next_cfg_wrl;

  cpg_byte_t   id_rdata;
  cpg_byte_t   rd_value;

  cpg_region_if rif ();

  cpg_region_decode #(
    .MEM_BYTES  (MEM_BYTES),
    .BOOT_BYTES (BOOT_BYTES)
  ) u_decode (
    .rif (rif)
  );

  // processor wins when both ask in the same cycle
  assign accept    = (state == CPG_ST_IDLE) && (core_req || prog_req);
  assign sel_prog  = !core_req;
  assign sel_wr    = sel_prog ? prog_wr    : core_wr;
  assign sel_ee    = sel_prog ? prog_ee    : core_ee;
  assign sel_addr  = sel_prog ? prog_addr  : table_pointer;
  assign sel_wdata = sel_prog ? prog_wdata : core_wdata;

  assign rif.target_addr = sel_addr;
  assign rif.pc_addr     = core_pc;
  assign tr              = rif.target_rgn;
  assign pr              = rif.pc_rgn;

  // classify the target of the selected request
  always_comb begin
    next_tgt = CPG_TGT_NONE;
    if (sel_ee) begin
      next_tgt = CPG_TGT_EE;
    end else if (tr != CPG_RGN_NONE) begin
      next_tgt = CPG_TGT_PROG;
    end else if ((sel_addr >= `CPG_REG_READ_GUARD_LOW) && (sel_addr <= `CPG_REG_BOOT_CROSS_READ_GUARD)) begin
      next_tgt = CPG_TGT_CFG;
    end else if ((sel_addr >= `CPG_ID_FIRST) && (sel_addr <= `CPG_ID_LAST)) begin
      next_tgt = CPG_TGT_ID;
    end else if ((sel_addr == `CPG_DEVID_LOW_ADDR) || (sel_addr == `CPG_DEVID_HIGH_ADDR)) begin
      next_tgt = CPG_TGT_DEVID;
    end
  end

  // permission check; the region index is only used when the target is in program memory
  always_comb begin
    next_ok = 1'b0;
    case (next_tgt)
      CPG_TGT_PROG: begin
        if (sel_prog) begin
          next_ok = region_external_lock[tr] && (!sel_wr || region_write_lock[tr]);
        end else if (sel_wr) begin
          next_ok = region_write_lock[tr];
        end else begin
          next_ok = region_cross_read_lock[tr] || (tr == pr);
        end
      end
      CPG_TGT_EE: begin
        if (sel_prog) begin
          next_ok = eeprom_external_lock && (!sel_wr || eeprom_write_lock);
        end else begin
          next_ok = !sel_wr || eeprom_write_lock;
        end
      end
      CPG_TGT_CFG: begin
        next_ok = !sel_wr || config_write_lock;
      end
      CPG_TGT_ID: begin
        next_ok = 1'b1;
      end
      default: begin
        // device id and holes are read-only, holes read as zero
        next_ok = !sel_wr;
      end
    endcase
  end

  assign cfg_wr_en = accept && (next_tgt == CPG_TGT_CFG) && sel_wr && next_ok;

  // writes can only clear bits; the processor never touches the config write lock
  always_comb begin
    next_ext     = region_external_lock;
    next_wrl     = region_write_lock;
    next_xrd     = region_cross_read_lock;
    next_ee_ext  = eeprom_external_lock;
    next_ee_wrl  = eeprom_write_lock;
    next_cfg_wrl = config_write_lock;
    if (cfg_wr_en) begin
      case (sel_addr)
        `CPG_REG_READ_GUARD_LOW: begin
          next_ext[CPG_RGN_BLK0] = region_external_lock[CPG_RGN_BLK0] & sel_wdata[`CPG_BIT_BLK0];
          next_ext[CPG_RGN_BLK1] = region_external_lock[CPG_RGN_BLK1] & sel_wdata[`CPG_BIT_BLK1];
        end
        `CPG_REG_BOOT_EEPROM_READ_GUARD: begin
          next_ext[CPG_RGN_BOOT] = region_external_lock[CPG_RGN_BOOT] & sel_wdata[`CPG_BIT_BOOT];
          next_ee_ext = eeprom_external_lock & sel_wdata[`CPG_BIT_EEPROM];
        end
        `CPG_REG_WRITE_GUARD_LOW: begin
          next_wrl[CPG_RGN_BLK0] = region_write_lock[CPG_RGN_BLK0] & sel_wdata[`CPG_BIT_BLK0];
          next_wrl[CPG_RGN_BLK1] = region_write_lock[CPG_RGN_BLK1] & sel_wdata[`CPG_BIT_BLK1];
        end
        `CPG_REG_BOOT_EEPROM_CFG_WR_GUARD: begin
          next_wrl[CPG_RGN_BOOT] = region_write_lock[CPG_RGN_BOOT] & sel_wdata[`CPG_BIT_BOOT];
          next_ee_wrl = eeprom_write_lock & sel_wdata[`CPG_BIT_EEPROM];
          if (sel_prog) begin
            next_cfg_wrl = config_write_lock & sel_wdata[`CPG_BIT_CFG_WRITE];
          end
        end
        `CPG_REG_CROSS_READ_GUARD_LOW: begin
          next_xrd[CPG_RGN_BLK0] = region_cross_read_lock[CPG_RGN_BLK0] & sel_wdata[`CPG_BIT_BLK0];
          next_xrd[CPG_RGN_BLK1] = region_cross_read_lock[CPG_RGN_BLK1] & sel_wdata[`CPG_BIT_BLK1];
        end
        `CPG_REG_BOOT_CROSS_READ_GUARD: begin
          next_xrd[CPG_RGN_BOOT] = region_cross_read_lock[CPG_RGN_BOOT] & sel_wdata[`CPG_BIT_BOOT];
        end
        default: begin
          next_ext = region_external_lock;
        end
      endcase
    end
    // erase sets bits back to one and wins over a clearing write in the same cycle
    if (prog_chip_erase) begin
      next_ext     = `CPG_ALL_REGIONS;
      next_wrl     = `CPG_ALL_REGIONS;
      next_xrd     = `CPG_ALL_REGIONS;
      next_ee_ext  = `CPG_LOCK_ERASED;
      next_ee_wrl  = `CPG_LOCK_ERASED;
      next_cfg_wrl = `CPG_LOCK_ERASED;
    end else if (prog_block_erase && (prog_erase_sel != CPG_RGN_NONE)) begin
      next_ext[prog_erase_sel] = `CPG_LOCK_ERASED;
      next_wrl[prog_erase_sel] = `CPG_LOCK_ERASED;
      next_xrd[prog_erase_sel] = `CPG_LOCK_ERASED;
    end
  end

  // protection bits; reset leaves a blank, unprotected part
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      region_external_lock   <= `CPG_ALL_REGIONS;
      region_write_lock      <= `CPG_ALL_REGIONS;
      region_cross_read_lock <= `CPG_ALL_REGIONS;
      eeprom_external_lock   <= `CPG_LOCK_ERASED;
      eeprom_write_lock      <= `CPG_LOCK_ERASED;
      config_write_lock      <= `CPG_LOCK_ERASED;
    end else begin
      region_external_lock   <= next_ext;
      region_write_lock      <= next_wrl;
      region_cross_read_lock <= next_xrd;
      eeprom_external_lock   <= next_ee_ext;
      eeprom_write_lock      <= next_ee_wrl;
      config_write_lock      <= next_cfg_wrl;
    end
  end

  // erase command to the array, only the programmer can start one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      erase_strobe  <= 1'b0;
      erase_regions <= '0;
      erase_eeprom  <= 1'b0;
    end else begin
      erase_strobe  <= prog_chip_erase || (prog_block_erase && (prog_erase_sel != CPG_RGN_NONE));
      erase_eeprom  <= prog_chip_erase;
      if (prog_chip_erase) begin
        erase_regions <= `CPG_ALL_REGIONS;
      end else if (prog_block_erase && (prog_erase_sel != CPG_RGN_NONE)) begin
        erase_regions <= 3'(1 << prog_erase_sel);
      end else begin
        erase_regions <= '0;
      end
    end
  end

  // fixed four cycle sequence: take, issue, capture, done
  always_comb begin
    case (state)
      CPG_ST_IDLE:    next_state = accept ? CPG_ST_ISSUE : CPG_ST_IDLE;
      CPG_ST_ISSUE:   next_state = CPG_ST_CAPTURE;
      CPG_ST_CAPTURE: next_state = CPG_ST_DONE;
      CPG_ST_DONE:    next_state = CPG_ST_IDLE;
      default:        next_state = CPG_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= CPG_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // hold the decided request for the rest of the sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_src_prog <= 1'b0;
      cur_wr       <= 1'b0;
      cur_ok       <= 1'b0;
      cur_tgt      <= CPG_TGT_NONE;
      cur_addr     <= '0;
    end else if (accept) begin
      cur_src_prog <= sel_prog;
      cur_wr       <= sel_wr;
      cur_ok       <= next_ok;
      cur_tgt      <= next_tgt;
      cur_addr     <= sel_addr;
    end
  end

  // array strobes are one-cycle pulses, and only for permitted accesses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      ee_rd     <= 1'b0;
      ee_wr     <= 1'b0;
      nvm_addr  <= '0;
      nvm_wdata <= '0;
    end else begin
      mem_rd <= accept && next_ok && (next_tgt == CPG_TGT_PROG) && !sel_wr;
      mem_wr <= accept && next_ok && (next_tgt == CPG_TGT_PROG) && sel_wr;
      ee_rd  <= accept && next_ok && (next_tgt == CPG_TGT_EE) && !sel_wr;
      ee_wr  <= accept && next_ok && (next_tgt == CPG_TGT_EE) && sel_wr;
      if (accept) begin
        nvm_addr  <= sel_addr;
        nvm_wdata <= sel_wdata;
      end
    end
  end

  cpg_id_mem #(
    .DEPTH (8),
    .WIDTH (8)
  ) u_id_mem (
    .clk   (clk),
    .nrst  (nrst),
    .wr_en (accept && (next_tgt == CPG_TGT_ID) && sel_wr),
    .rd_en (accept && (next_tgt == CPG_TGT_ID) && !sel_wr),
    .index (sel_addr[2:0]),
    .wdata (sel_wdata),
    .rdata (id_rdata)
  );

  // read value of the held request; unused bits of guard registers read zero
  always_comb begin
    rd_value = `CPG_BYTE_ZERO;
    case (cur_tgt)
      CPG_TGT_PROG: rd_value = mem_rdata;
      CPG_TGT_EE:   rd_value = ee_rdata;
      CPG_TGT_ID:   rd_value = id_rdata;
      CPG_TGT_DEVID: rd_value = (cur_addr == `CPG_DEVID_HIGH_ADDR) ? DEVID_HIGH : DEVID_LOW;
      CPG_TGT_CFG: begin
        case (cur_addr)
          `CPG_REG_READ_GUARD_LOW: begin
            rd_value[`CPG_BIT_BLK0] = region_external_lock[CPG_RGN_BLK0];
            rd_value[`CPG_BIT_BLK1] = region_external_lock[CPG_RGN_BLK1];
          end
          `CPG_REG_BOOT_EEPROM_READ_GUARD: begin
            rd_value[`CPG_BIT_BOOT]   = region_external_lock[CPG_RGN_BOOT];
            rd_value[`CPG_BIT_EEPROM] = eeprom_external_lock;
          end
          `CPG_REG_WRITE_GUARD_LOW: begin
            rd_value[`CPG_BIT_BLK0] = region_write_lock[CPG_RGN_BLK0];
            rd_value[`CPG_BIT_BLK1] = region_write_lock[CPG_RGN_BLK1];
          end
          `CPG_REG_BOOT_EEPROM_CFG_WR_GUARD: begin
            rd_value[`CPG_BIT_BOOT]      = region_write_lock[CPG_RGN_BOOT];
            rd_value[`CPG_BIT_EEPROM]    = eeprom_write_lock;
            rd_value[`CPG_BIT_CFG_WRITE] = config_write_lock;
          end
          `CPG_REG_CROSS_READ_GUARD_LOW: begin
            rd_value[`CPG_BIT_BLK0] = region_cross_read_lock[CPG_RGN_BLK0];
            rd_value[`CPG_BIT_BLK1] = region_cross_read_lock[CPG_RGN_BLK1];
          end
          `CPG_REG_BOOT_CROSS_READ_GUARD: begin
            rd_value[`CPG_BIT_BOOT] = region_cross_read_lock[CPG_RGN_BOOT];
          end
          default: rd_value = `CPG_BYTE_ZERO;
        endcase
      end
      default: rd_value = `CPG_BYTE_ZERO;
    endcase
  end

  // latch loads on reads only; a refused read loads zero so nothing leaks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      table_latch <= `CPG_BYTE_ZERO;
    end else if ((state == CPG_ST_CAPTURE) && !cur_wr) begin
      table_latch <= cur_ok ? rd_value : `CPG_BYTE_ZERO;
    end
  end

  // completion pulses go back to whoever asked
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_done    <= 1'b0;
      core_refused <= 1'b0;
      prog_done    <= 1'b0;
      prog_refused <= 1'b0;
    end else begin
      core_done    <= (state == CPG_ST_CAPTURE) && !cur_src_prog;
      core_refused <= (state == CPG_ST_CAPTURE) && !cur_src_prog && !cur_ok;
      prog_done    <= (state == CPG_ST_CAPTURE) && cur_src_prog;
      prog_refused <= (state == CPG_ST_CAPTURE) && cur_src_prog && !cur_ok;
    end
  end

endmodule // cpg_gate

// *** cpg_regs.svh ***
// register offsets, bit positions and reset values of the code protection gate
`ifndef CPG_REGS_SVH
`define CPG_REGS_SVH

// width of the table pointer and program counter address space
`define CPG_ADDR_W 22

// protection register offsets in configuration space
`define CPG_REG_READ_GUARD_LOW           22'h300008
`define CPG_REG_BOOT_EEPROM_READ_GUARD   22'h300009
`define CPG_REG_WRITE_GUARD_LOW          22'h30000A
`define CPG_REG_BOOT_EEPROM_CFG_WR_GUARD 22'h30000B
`define CPG_REG_CROSS_READ_GUARD_LOW     22'h30000C
`define CPG_REG_BOOT_CROSS_READ_GUARD    22'h30000D

// user identification bytes and device identification word
`define CPG_ID_FIRST        22'h200000
`define CPG_ID_LAST         22'h200007
`define CPG_DEVID_LOW_ADDR  22'h3FFFFE
`define CPG_DEVID_HIGH_ADDR 22'h3FFFFF

// bit positions inside the protection registers
`define CPG_BIT_BLK0       0
`define CPG_BIT_BLK1       1
`define CPG_BIT_BOOT       6
`define CPG_BIT_EEPROM     7
`define CPG_BIT_CFG_WRITE  5

// erased values and region size limit
`define CPG_LOCK_ERASED     1'b1
`define CPG_ID_ERASED       8'hFF
`define CPG_BYTE_ZERO       8'h00
`define CPG_BOOT_MAX_BYTES  2048
`define CPG_ALL_REGIONS     3'h7

`endif

// *** cpg_pkg.sv ***
// types shared by the code protection gate modules
package cpg_pkg;

  typedef logic [21:0] cpg_addr_t;
  typedef logic [7:0]  cpg_byte_t;

  // program memory protection regions, also the index into the lock vectors
  typedef enum logic [1:0] {
    CPG_RGN_BOOT = 2'h0,
    CPG_RGN_BLK0 = 2'h1,
    CPG_RGN_BLK1 = 2'h2,
    CPG_RGN_NONE = 2'h3
  } cpg_region_e;

  // access sequencer, one-hot
  typedef enum logic [3:0] {
    CPG_ST_IDLE    = 4'h1,
    CPG_ST_ISSUE   = 4'h2,
    CPG_ST_CAPTURE = 4'h4,
    CPG_ST_DONE    = 4'h8
  } cpg_state_e;

  // what a table access lands on
  typedef enum logic [2:0] {
    CPG_TGT_PROG  = 3'h0,
    CPG_TGT_EE    = 3'h1,
    CPG_TGT_CFG   = 3'h2,
    CPG_TGT_ID    = 3'h3,
    CPG_TGT_DEVID = 3'h4,
    CPG_TGT_NONE  = 3'h5
  } cpg_target_e;

endpackage

// *** cpg_region_if.sv ***
// address to region lookup carried between the gate and its decoder
`timescale 1ns/100ps
interface cpg_region_if;
  cpg_pkg::cpg_addr_t   target_addr;
  cpg_pkg::cpg_addr_t   pc_addr;
  cpg_pkg::cpg_region_e target_rgn;
  cpg_pkg::cpg_region_e pc_rgn;

  modport decoder (input target_addr, input pc_addr, output target_rgn, output pc_rgn);
  modport user (output target_addr, output pc_addr, input target_rgn, input pc_rgn);
endinterface

// *** cpg_region_decode.sv ***
// combinational decode of target and program counter addresses into regions
`timescale 1ns/100ps
`include "cpg_regs.svh"
module cpg_region_decode #(
  parameter int unsigned MEM_BYTES  = 8192,
  parameter int unsigned BOOT_BYTES = 2048
) (
  cpg_region_if.decoder rif
);
  import cpg_pkg::*;

  // boot region is clamped to its largest legal size
  localparam int unsigned BOOT_EFF = (BOOT_BYTES > `CPG_BOOT_MAX_BYTES) ? `CPG_BOOT_MAX_BYTES : BOOT_BYTES;
  localparam cpg_addr_t BOOT_LIMIT = cpg_addr_t'(BOOT_EFF);
  localparam cpg_addr_t BLK1_BASE  = cpg_addr_t'(MEM_BYTES / 2);
  localparam cpg_addr_t MEM_LIMIT  = cpg_addr_t'(MEM_BYTES);

  // upper block starts at the binary half of memory, block 0 fills the gap
  function automatic cpg_region_e region_of(input cpg_addr_t a);
    cpg_region_e r;
    r = CPG_RGN_NONE;
    if (a < BOOT_LIMIT) begin
      r = CPG_RGN_BOOT;
    end else if (a < BLK1_BASE) begin
      r = CPG_RGN_BLK0;
    end else if (a < MEM_LIMIT) begin
      r = CPG_RGN_BLK1;
    end
    return r;
  endfunction

  // both lookups run in parallel for every request
  assign rif.target_rgn = region_of(rif.target_addr);
  assign rif.pc_rgn     = region_of(rif.pc_addr);

endmodule // cpg_region_decode

// *** cpg_id_mem.sv ***
// user identification byte store with registered read data
`timescale 1ns/100ps
`include "cpg_regs.svh"
module cpg_id_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] index,
  input  wire logic [WIDTH-1:0]         wdata,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] cells [DEPTH];

  // one storage cell per entry, erased state after reset
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cells[i] <= WIDTH'(`CPG_ID_ERASED);
      end else if (wr_en && (index == i)) begin
        cells[i] <= wdata;
      end
    end
  end

  // read port is registered, data valid the cycle after rd_en
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= cells[index];
    end
  end

endmodule // cpg_id_mem

// *** cpg_nvm_model.sv ***
// behavioural program memory and data eeprom behind the gate
`timescale 1ns/100ps
module cpg_nvm_model
  import cpg_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      mem_rd,
  input  wire logic      ee_rd,
  input  wire cpg_addr_t nvm_addr,
  output cpg_byte_t      mem_rdata = 8'h00,
  output cpg_byte_t      ee_rdata = 8'h00
);
  // data only in the capture cycle; it toggles otherwise so a stale sample never matches
  always_ff @(posedge clk) begin
    mem_rdata <= mem_rd ? nvm_addr[7:0] ^ 8'hA5 : ~mem_rdata;
    ee_rdata  <= ee_rd ? nvm_addr[7:0] ^ 8'h3C : ~ee_rdata;
  end
endmodule // cpg_nvm_model

// *** cpg_gate_checker.sv ***
// concurrent checks on the code protection gate ports
`timescale 1ns/100ps
module cpg_gate_checker
  import cpg_pkg::*;
(
  input wire logic clk, nrst, core_req, core_wr, core_ee, prog_chip_erase, prog_block_erase,
  input wire cpg_region_e prog_erase_sel,
  input wire logic core_done, core_refused, prog_done, prog_refused,
  input wire logic mem_rd, mem_wr, ee_rd, ee_wr, erase_strobe, erase_eeprom,
  input wire logic [2:0] erase_regions,
  input wire cpg_byte_t table_latch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // an accepted access ends two cycles after its strobe, not refused
  sequence s_ok;
    ##2 (core_done || prog_done) && !core_refused && !prog_refused;
  endsequence
  // spacing: no answer in the three cycles after one
  sequence s_quiet;
    (!core_done && !prog_done) [*3];
  endsequence
  rd_strobe_a: assert property ((mem_rd || ee_rd) |-> s_ok) else $error("read strobe not answered");
  wr_strobe_a: assert property ((mem_wr || ee_wr) |-> s_ok) else $error("write strobe not answered");
  done_gap_a: assert property ((core_done || prog_done) |=> s_quiet) else $error("answers too close");
  ref_done_a: assert property (core_refused |-> core_done) else $error("refusal without done");
  ref_zero_a: assert property (core_done && core_refused && !$past(core_wr, 3) |-> table_latch == 8'h00)
    else $error("refused read latch not zero");
  ee_read_a: assert property (core_done && $past(core_ee, 3) && !$past(core_wr, 3) |-> !core_refused)
    else $error("eeprom read refused");
  chip_erase_a: assert property (prog_chip_erase |=> erase_strobe && erase_regions == 3'h7 && erase_eeprom)
    else $error("chip erase wrong");
  blk_erase_a: assert property (prog_block_erase && !prog_chip_erase && prog_erase_sel != CPG_RGN_NONE
    |=> erase_strobe && erase_regions == 3'h1 << $past(prog_erase_sel)) else $error("block erase wrong");
  erase_src_a: assert property (erase_strobe |-> $past(prog_chip_erase) || $past(prog_block_erase))
    else $error("erase without programmer");
  latch_hold_a: assert property (!core_done && !prog_done |-> $stable(table_latch)) else $error("latch moved");
  // a refused write must never have strobed the array two cycles before its answer
  ref_quiet_a: assert property (core_refused || prog_refused |-> !$past(mem_wr, 2) && !$past(ee_wr, 2))
    else $error("refused write reached array");
endmodule // cpg_gate_checker
bind cpg_gate cpg_gate_checker u_chk (.*);

// *** tb_top.sv ***
// self-checking bench for the code protection gate
`timescale 1ns/100ps
`include "cpg_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("wrong value %0t mismatch", $time); end end
module tb_top;
  import cpg_pkg::*;
  localparam cpg_byte_t DEV_LO = 8'h5C; // arbitrary value
  logic clk = 0, nrst = 0, core_req = 0, core_wr = 0, core_ee = 0, prog_req = 0, prog_wr = 0, prog_ee = 0;
  logic prog_chip_erase = 0, prog_block_erase = 0, core_done, core_refused, prog_done, prog_refused;
  logic mem_rd, mem_wr, ee_rd, ee_wr, erase_strobe, erase_eeprom;
  logic [2:0] erase_regions;
  cpg_addr_t table_pointer = 0, core_pc = 0, prog_addr = 0, nvm_addr, a, pc;
  cpg_byte_t core_wdata = 0, prog_wdata = 0, table_latch, nvm_wdata, mem_rdata, ee_rdata, d;
  cpg_region_e prog_erase_sel = CPG_RGN_NONE;
  int miscompares = 0, comparisons = 0, i;
  cpg_gate #(.DEVID_LOW(DEV_LO)) u_dut (.*);
  cpg_nvm_model u_mem (.*);
  always #20 clk = ~clk;
  // expected memory contents, same pattern as the far side stores
  function automatic cpg_byte_t fm(cpg_addr_t x); return x[7:0] ^ 8'hA5; endfunction
  function automatic cpg_byte_t fe(cpg_addr_t x); return x[7:0] ^ 8'h3C; endfunction
  // one table access; p selects the programmer, m masks the latch compare
  task automatic acc(input logic p, w, e, cpg_addr_t ad, pcv, cpg_byte_t wd, logic xr, cpg_byte_t xl, m);
    int n;
    @(posedge clk);
    #1;
    if (p) begin
      {prog_req, prog_wr, prog_ee, prog_addr, prog_wdata} = {1'b1, w, e, ad, wd};
    end else begin
      {core_req, core_wr, core_ee, table_pointer, core_pc, core_wdata} = {1'b1, w, e, ad, pcv, wd};
    end
    n = 0;
    do begin @(posedge clk); #1; n++; end while (core_done !== 1'b1 && prog_done !== 1'b1 && n < 8);
    `CHK(n, 3)
    `CHK(core_refused | prog_refused, xr)
    `CHK(table_latch & m, xl & m)
    `CHK({nvm_addr, nvm_wdata}, {ad, wd})
    core_req = 0;
    prog_req = 0;
  endtask
  // erase pulse, strobe expected in the next cycle
  task automatic ers(input logic chip, cpg_region_e s);
    @(posedge clk);
    #1;
    {prog_chip_erase, prog_block_erase, prog_erase_sel} = {chip, !chip, s};
    @(posedge clk);
    #1;
    `CHK({erase_strobe, erase_regions}, {1'b1, chip ? 3'h7 : 3'(1 << s)})
    {prog_chip_erase, prog_block_erase} = 2'b00;
  endtask
  task test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog far beyond the roughly 180 cycles the sequence needs
  initial begin
    #100000;
    miscompares++;
    test_done;
  end
  initial begin
    void'($urandom(32'h9b450152));
    repeat (16) @(posedge clk);
    #1 nrst = 1;
    `CHK({core_done, prog_done, mem_rd, erase_strobe, table_latch}, 12'h000)
    acc(0, 0, 0, `CPG_REG_READ_GUARD_LOW, 0, 0, 0, 8'h03, 8'h03);
    for (i = 0; i < 6; i++) begin
      a = 22'($urandom_range(8191));
      pc = 22'($urandom_range(8191));
      acc(0, 0, 0, a, pc, 0, 0, fm(a), 8'hFF);
    end
    d = 8'($urandom);
    acc(0, 1, 0, 22'h200003, 0, d, 0, 0, 0);
    acc(0, 0, 0, 22'h200003, 0, 0, 0, d, 8'hFF);
    acc(0, 0, 0, `CPG_DEVID_LOW_ADDR, 0, 0, 0, DEV_LO, 8'hFF);
    acc(0, 0, 0, 22'h002000, 0, 0, 0, 0, 8'hFF);
    acc(0, 1, 0, 22'h002000, 0, 8'h12, 1, 0, 0);
    acc(0, 1, 0, `CPG_REG_BOOT_CROSS_READ_GUARD, 0, 8'hBF, 0, 0, 0);
    acc(0, 0, 0, 22'h000100, 22'h000900, 0, 1, 0, 8'hFF);
    acc(0, 0, 0, 22'h000100, 22'h0007FE, 0, 0, fm(22'h100), 8'hFF);
    acc(0, 1, 0, `CPG_REG_BOOT_CROSS_READ_GUARD, 0, 8'hFF, 0, 0, 0);
    acc(0, 0, 0, `CPG_REG_BOOT_CROSS_READ_GUARD, 0, 0, 0, 8'h00, 8'h40);
    acc(0, 1, 0, `CPG_REG_WRITE_GUARD_LOW, 0, 8'hFE, 0, 0, 0);
    acc(0, 1, 0, 22'h000900, 0, 8'h12, 1, 0, 0);
    acc(0, 1, 0, 22'h001900, 0, 8'h12, 0, 0, 0);
    acc(0, 1, 0, `CPG_REG_READ_GUARD_LOW, 0, 8'hFD, 0, 0, 0);
    acc(0, 0, 0, 22'h001234, 0, 0, 0, fm(22'h1234), 8'hFF);
    acc(1, 0, 0, 22'h001234, 0, 0, 1, 0, 8'hFF);
    acc(1, 1, 0, 22'h001234, 0, 8'h05, 1, 0, 0);
    acc(1, 0, 0, 22'h000A00, 0, 0, 0, fm(22'hA00), 8'hFF);
    acc(1, 0, 1, 22'h000010, 0, 0, 0, fe(22'h10), 8'hFF);
    acc(0, 1, 0, `CPG_REG_BOOT_EEPROM_READ_GUARD, 0, 8'h7F, 0, 0, 0);
    acc(1, 0, 1, 22'h000010, 0, 0, 1, 0, 8'hFF);
    acc(0, 1, 0, `CPG_REG_BOOT_EEPROM_CFG_WR_GUARD, 0, 8'h7F, 0, 0, 0);
    acc(0, 1, 1, 22'h000010, 0, 8'h33, 1, 0, 0);
    acc(1, 1, 1, 22'h000010, 0, 8'h33, 1, 0, 0);
    acc(0, 0, 1, 22'h000010, 0, 0, 0, fe(22'h10), 8'hFF);
    acc(0, 1, 0, `CPG_REG_BOOT_EEPROM_CFG_WR_GUARD, 0, 8'h00, 0, 0, 0);
    acc(0, 0, 0, `CPG_REG_BOOT_EEPROM_CFG_WR_GUARD, 0, 0, 0, 8'h20, 8'hE0);
    acc(0, 0, 0, 22'h200003, 22'h001000, 0, 0, d, 8'hFF);
    acc(1, 1, 0, `CPG_REG_BOOT_EEPROM_CFG_WR_GUARD, 0, 8'hDF, 0, 0, 0);
    acc(0, 1, 0, `CPG_REG_READ_GUARD_LOW, 0, 8'h00, 1, 0, 0);
    ers(0, CPG_RGN_BOOT);
    acc(0, 0, 0, `CPG_REG_BOOT_CROSS_READ_GUARD, 0, 0, 0, 8'h40, 8'h40);
    ers(1, CPG_RGN_NONE);
    acc(0, 0, 0, `CPG_REG_READ_GUARD_LOW, 0, 0, 0, 8'h03, 8'h03);
    acc(0, 0, 0, `CPG_REG_BOOT_EEPROM_CFG_WR_GUARD, 0, 0, 0, 8'hE0, 8'hE0);
    test_done;
  end
endmodule // tb_top
